// *** rtl/crrsc_i2c_link.sv ***
// serial link engine running on the link clock
`timescale 1ns/100ps
module crrsc_i2c_link (
  input  wire logic                    scl,
  input  wire logic                    linkReset,
  input  wire logic                    frameReset,
  input  wire logic                    sdaIn,
  input  wire logic [7:0]              rdData,
  output logic                         sdaOut,
  output logic                         sdaOe,
  output logic                         wrToggle,
  output crrsc_pkg::crrsc_link_wr_s    wrReq,
  output logic                         rdToggle,
  output logic [7:0]                   rdPtr
);
  import crrsc_pkg::*;

  typedef enum logic [4:0] {
    ST_ADDR   = 5'h01,
    ST_REG    = 5'h02,
    ST_WDATA  = 5'h04,
    ST_RDATA  = 5'h08,
    ST_IGNORE = 5'h10
  } crrsc_link_e;

  crrsc_link_e state_q;
  logic [3:0]  bitCnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  txByte_q;
  logic        ack_q;
  logic        rw_q;
  logic [7:0]  rxByte;

  assign rxByte = {shift_q[6:0], sdaIn};
  // open drain: only ever pulls low
  assign sdaOut = 1'b0;

  // ******************************
  // byte framing, sampled on rising edge
  // ******************************
  always_ff @(posedge scl or posedge frameReset) begin
    if (frameReset) begin
      state_q  <= ST_ADDR;
      bitCnt_q <= 4'h0;
      shift_q  <= 8'h00;
      ack_q    <= 1'b0;
      rw_q     <= 1'b0;
    end else begin
      bitCnt_q <= (bitCnt_q == ACK_SLOT) ? 4'h0 : bitCnt_q + 4'h1;
      if (bitCnt_q != ACK_SLOT) begin
        shift_q <= rxByte;
      end
      if (bitCnt_q == BIT_LAST) begin
        unique case (state_q)
          ST_ADDR: begin
            ack_q <= (rxByte[7:1] == DEV_ADDR);
            rw_q  <= rxByte[0];
          end
          ST_REG, ST_WDATA: ack_q <= 1'b1;
          ST_RDATA, ST_IGNORE: ack_q <= 1'b0;
        endcase
      end
      if (bitCnt_q == ACK_SLOT) begin
        unique case (state_q)
          ST_ADDR: state_q <= !ack_q ? ST_IGNORE : (rw_q ? ST_RDATA : ST_REG);
          ST_REG: state_q <= ST_WDATA;
          ST_WDATA: state_q <= ST_WDATA;
          ST_RDATA: state_q <= sdaIn ? ST_IGNORE : ST_RDATA;
          ST_IGNORE: state_q <= ST_IGNORE;
        endcase
      end
    end
  end

  // ******************************
  // pointer and requests to the register side
  // ******************************
  always_ff @(posedge scl or posedge linkReset) begin
    if (linkReset) begin
      rdPtr    <= 8'h00;
      wrToggle <= 1'b0;
      rdToggle <= 1'b0;
      wrReq    <= '0;
    end else if (bitCnt_q == ACK_SLOT) begin
      unique case (state_q)
        ST_ADDR: rdToggle <= rdToggle ^ (ack_q & rw_q);
        ST_REG: rdPtr <= shift_q;
        ST_WDATA: begin
          wrReq.addr <= rdPtr;
          wrReq.data <= shift_q;
          wrToggle   <= ~wrToggle;
          rdPtr      <= rdPtr + 8'h01;
        end
        ST_RDATA: begin
          rdPtr    <= rdPtr + 8'h01;
          rdToggle <= rdToggle ^ ~sdaIn;
        end
        ST_IGNORE: rdPtr <= rdPtr;
      endcase
    end
  end

  // ******************************
  // data and acknowledge drive on falling edge
  // ******************************
  always_ff @(negedge scl or posedge frameReset) begin
    if (frameReset) begin
      sdaOe    <= 1'b0;
      txByte_q <= 8'h00;
    end else if (bitCnt_q == ACK_SLOT) begin
      sdaOe <= ack_q;
    end else if (state_q == ST_RDATA) begin
      if (bitCnt_q == 4'h0) begin
        txByte_q <= rdData;
        sdaOe    <= ~rdData[7];
      end else begin
        sdaOe <= ~txByte_q[3'(BIT_LAST - bitCnt_q)];
      end
    end else begin
      sdaOe <= 1'b0;
    end
  end

endmodule

// *** rtl/crrsc_pkg.sv ***
// constants and types shared by the colour result register bank
package crrsc_pkg;

  // ******************************
  // link and register map
  // ******************************
  localparam logic [6:0] DEV_ADDR       = 7'h39;
  localparam logic [7:0] ADDR_GAIN_CFG  = 8'h90;
  localparam logic [7:0] ADDR_STATUS    = 8'h93;
  localparam logic [7:0] ADDR_Z_LO      = 8'h94;
  localparam logic [7:0] ADDR_Z_HI      = 8'h95;
  localparam logic [7:0] ADDR_Y_LO      = 8'h96;
  localparam logic [7:0] ADDR_Y_HI      = 8'h97;
  localparam logic [7:0] ADDR_IRA_LO    = 8'h98;
  localparam logic [7:0] ADDR_IRA_HI    = 8'h99;
  localparam logic [7:0] ADDR_FOURTH_LO = 8'h9A;
  localparam logic [7:0] ADDR_FOURTH_HI = 8'h9B;
  localparam logic [7:0] ADDR_HIGH_GAIN = 8'h9F;
  localparam logic [7:0] ADDR_INT_CFG   = 8'hAB;

  // ******************************
  // reset values and fields
  // ******************************
  localparam logic [7:0]  GAIN_CFG_RST  = 8'h00;
  localparam logic [7:0]  HIGH_GAIN_RST = 8'h04;
  localparam logic [7:0]  INT_CFG_RST   = 8'h0C;
  localparam logic [15:0] RESULT_RST    = 16'h0000;
  localparam logic [7:0]  READ_ZERO     = 8'h00;
  localparam int          FOURTH_SEL_BIT = 3;
  localparam int          GSEL_MSB      = 1;
  localparam int          GSEL_LSB      = 0;
  localparam logic [1:0]  GSEL_TOP      = 2'h3;
  localparam int          HIGH_GAIN_BIT = 4;
  localparam int          CLR_ON_READ_BIT = 7;
  localparam int          SLEEP_INT_BIT = 4;
  localparam int          SAT_BIT       = 7;
  localparam int          LINT_BIT      = 4;

  // ******************************
  // link bit timing
  // ******************************
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  typedef enum logic [2:0] {
    GAIN_1X   = 3'h0,
    GAIN_4X   = 3'h1,
    GAIN_16X  = 3'h2,
    GAIN_64X  = 3'h3,
    GAIN_128X = 3'h4
  } crrsc_gain_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } crrsc_link_wr_s;

  typedef struct packed {
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] infraredA;
    logic [15:0] x;
    logic [15:0] infraredB;
  } crrsc_conv_s;

endpackage

// *** rtl/crrsc_regs.sv ***
// colour result register bank with gain and sleep-after-interrupt control
//
// Summary of operation
// [R1] Z result is 16 bits: low byte at 0x94, high byte at 0x95.
// [R2] Y result is 16 bits: low byte at 0x96, high byte at 0x97.
// [R3] First infrared result: low byte at 0x98, high byte at 0x99.
// [R4] Fourth pair holds X when select is 0, second infrared when 1.
// [R5] All eight result bytes are read-only and read zero after reset.
// [R6] 128x gain only with high-gain bit set and gain select equal to 11.
// [R7] Host writes 000 and 0100 into reserved high-gain config bits.
// [R8] With clear-on-read set, a status read clears the status flags.
// [R9] With sleep-after-interrupt set, sleep after a cycle raising an interrupt.
// [R10] Oscillator off without power-on, stopped when interrupt low with sleep set.
// [R11] Sleep changes no register bit; only interrupt level gates oscillator.
// [R12] Sleep ends only when the host clears the pending interrupt status or the sleep-after-interrupt bit.
// [R13] Low four interrupt config bits reset to 1100, store anything, do nothing.
// [R14] Gain select 00, 01, 10, 11 give 1x, 4x, 16x, 64x.
// [R15] Select bit 3 of gain config picks X or second infrared.
// [R16] Saturation and light interrupt flags clear on writing 1.
// [R17] High-gain bit without gain select 11 leaves plain gain select.
`timescale 1ns/100ps
module crrsc_regs (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    scl,
  input  wire logic                    sdaIn,
  output logic                         sdaOut,
  output logic                         sdaOe,
  input  wire logic                    intNIn,
  output logic                         intNOut,
  output logic                         intNOe,
  input  wire logic                    powerOn,
  input  wire logic                    convDone,
  input  wire crrsc_pkg::crrsc_conv_s  conv,
  input  wire logic                    lightIntEvent,
  input  wire logic                    saturationEvent,
  output crrsc_pkg::crrsc_gain_e       analogGain,
  output logic                         fourthChannelSelect,
  output logic                         oscEnable
);
  import crrsc_pkg::*;

  // ******************************
  // declarations
  // ******************************
  logic           sclMeta_q;
  logic           sclSync_q;
  logic           sdaMeta_q;
  logic           sdaSync_q;
  logic           sdaPrev_q;
  logic           frameReset_q;
  logic           startSeen;
  logic           stopSeen;

  logic           wrTogMeta_q;
  logic           wrTogSync_q;
  logic           wrTogPrev_q;
  logic           rdTogMeta_q;
  logic           rdTogSync_q;
  logic           rdTogPrev_q;
  logic           wrEvent;
  logic           rdEvent;

  logic           linkWrToggle;
  logic           linkRdToggle;
  crrsc_link_wr_s linkWr;
  logic [7:0]     linkPtr;
  logic [7:0]     rdData_q;

  logic [7:0]     gainCfg_q;
  logic [7:0]     highGainCfg_q;
  logic [7:0]     intCfg_q;
  logic           satFlag_q;
  logic           lightIntFlag_q;
  logic [15:0]    zRes_q;
  logic [15:0]    yRes_q;
  logic [15:0]    irARes_q;
  logic [15:0]    fourthRes_q;

  logic           intLowMeta_q;
  logic           intLowSync_q;

  logic           wrStatus;
  logic           rdStatusClear;
  logic           satClear;
  logic           lightIntClear;
  logic [7:0]     statusView;

  // ******************************
  // link engine on the link clock
  // ******************************
  crrsc_i2c_link u_link (
    .scl        (scl),
    .linkReset  (reset),
    .frameReset (frameReset_q),
    .sdaIn      (sdaIn),
    .rdData     (rdData_q),
    .sdaOut     (sdaOut),
    .sdaOe      (sdaOe),
    .wrToggle   (linkWrToggle),
    .wrReq      (linkWr),
    .rdToggle   (linkRdToggle),
    .rdPtr      (linkPtr)
  );

  // ******************************
  // bus line synchronisers
  // ******************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclMeta_q <= 1'b1;
      sclSync_q <= 1'b1;
      sdaMeta_q <= 1'b1;
      sdaSync_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclMeta_q <= scl;
      sclSync_q <= sclMeta_q;
      sdaMeta_q <= sdaIn;
      sdaSync_q <= sdaMeta_q;
      sdaPrev_q <= sdaSync_q;
    end
  end

  assign startSeen = sclSync_q & sdaPrev_q & ~sdaSync_q;
  assign stopSeen  = sclSync_q & ~sdaPrev_q & sdaSync_q;

  // ******************************
  // frame restart
  // ******************************
  // start or stop holds the framer in reset until the clock line falls,
  // so its release never meets a rising link clock edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frameReset_q <= 1'b1;
    end else if (startSeen || stopSeen) begin
      frameReset_q <= 1'b1;
    end else if (!sclSync_q) begin
      frameReset_q <= 1'b0;
    end
  end

  // ******************************
  // request toggle synchronisers
  // ******************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrTogMeta_q <= 1'b0;
      wrTogSync_q <= 1'b0;
      wrTogPrev_q <= 1'b0;
      rdTogMeta_q <= 1'b0;
      rdTogSync_q <= 1'b0;
      rdTogPrev_q <= 1'b0;
    end else begin
      wrTogMeta_q <= linkWrToggle;
      wrTogSync_q <= wrTogMeta_q;
      wrTogPrev_q <= wrTogSync_q;
      rdTogMeta_q <= linkRdToggle;
      rdTogSync_q <= rdTogMeta_q;
      rdTogPrev_q <= rdTogSync_q;
    end
  end

  // write data and pointer stay still for a whole byte after a toggle
  assign wrEvent = wrTogSync_q ^ wrTogPrev_q;
  assign rdEvent = rdTogSync_q ^ rdTogPrev_q;

  // ******************************
  // configuration registers
  // ******************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gainCfg_q <= GAIN_CFG_RST;
    end else if (wrEvent && linkWr.addr == ADDR_GAIN_CFG) begin
      gainCfg_q <= linkWr.data;
    end
  end

  // reserved bits are stored as written; the host keeps them at 000/0100
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      highGainCfg_q <= HIGH_GAIN_RST;
    end else if (wrEvent && linkWr.addr == ADDR_HIGH_GAIN) begin
      highGainCfg_q <= linkWr.data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      intCfg_q <= INT_CFG_RST; // R13
    end else if (wrEvent && linkWr.addr == ADDR_INT_CFG) begin
      intCfg_q <= linkWr.data; // R13
    end
  end

  // ******************************
  // status flags
  // ******************************
  assign wrStatus      = wrEvent && (linkWr.addr == ADDR_STATUS);
  assign rdStatusClear = rdEvent && (linkPtr == ADDR_STATUS)
                         && intCfg_q[CLR_ON_READ_BIT]; // R8
  assign satClear      = (wrStatus && linkWr.data[SAT_BIT]) || rdStatusClear; // R16
  assign lightIntClear = (wrStatus && linkWr.data[LINT_BIT]) || rdStatusClear; // R16

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      satFlag_q <= 1'b0;
    end else if (saturationEvent) begin
      satFlag_q <= 1'b1;
    end else if (satClear) begin
      satFlag_q <= 1'b0; // R16
    end
  end

  // raised at the end of the sensing cycle that produced the interrupt
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lightIntFlag_q <= 1'b0;
    end else if (convDone && lightIntEvent) begin
      lightIntFlag_q <= 1'b1; // R9
    end else if (lightIntClear) begin
      lightIntFlag_q <= 1'b0; // R12
    end
  end

  always_comb begin
    statusView           = READ_ZERO;
    statusView[SAT_BIT]  = satFlag_q;
    statusView[LINT_BIT] = lightIntFlag_q;
  end

  // ******************************
  // conversion results
  // ******************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      zRes_q      <= RESULT_RST; // R5
      yRes_q      <= RESULT_RST; // R5
      irARes_q    <= RESULT_RST; // R5
      fourthRes_q <= RESULT_RST; // R5
    end else if (convDone) begin
      zRes_q   <= conv.z;
      yRes_q   <= conv.y;
      irARes_q <= conv.infraredA;
      fourthRes_q <= gainCfg_q[FOURTH_SEL_BIT] ? conv.infraredB : conv.x; // R4 R15
    end
  end

  // ******************************
  // read data for the link
  // ******************************
  // results have no write path, so writes to them are dropped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdData_q <= READ_ZERO;
    end else if (rdEvent) begin
      unique case (linkPtr)
        ADDR_GAIN_CFG:  rdData_q <= gainCfg_q;
        ADDR_STATUS:    rdData_q <= statusView;
        ADDR_Z_LO:      rdData_q <= zRes_q[7:0]; // R1
        ADDR_Z_HI:      rdData_q <= zRes_q[15:8]; // R1
        ADDR_Y_LO:      rdData_q <= yRes_q[7:0]; // R2
        ADDR_Y_HI:      rdData_q <= yRes_q[15:8]; // R2
        ADDR_IRA_LO:    rdData_q <= irARes_q[7:0]; // R3
        ADDR_IRA_HI:    rdData_q <= irARes_q[15:8]; // R3
        ADDR_FOURTH_LO: rdData_q <= fourthRes_q[7:0]; // R4
        ADDR_FOURTH_HI: rdData_q <= fourthRes_q[15:8]; // R4
        ADDR_HIGH_GAIN: rdData_q <= highGainCfg_q;
        ADDR_INT_CFG:   rdData_q <= intCfg_q;
        default:        rdData_q <= READ_ZERO;
      endcase
    end
  end

  // ******************************
  // analog gain and channel select
  // ******************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      analogGain <= GAIN_1X;
    end else if (highGainCfg_q[HIGH_GAIN_BIT] && gainCfg_q[GSEL_MSB:GSEL_LSB] == GSEL_TOP) begin
      analogGain <= GAIN_128X; // R6
    end else begin
      unique case (gainCfg_q[GSEL_MSB:GSEL_LSB]) // R14 R17
        2'h0: analogGain <= GAIN_1X;
        2'h1: analogGain <= GAIN_4X;
        2'h2: analogGain <= GAIN_16X;
        2'h3: analogGain <= GAIN_64X;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fourthChannelSelect <= 1'b0;
    end else begin
      fourthChannelSelect <= gainCfg_q[FOURTH_SEL_BIT]; // R15
    end
  end

  // ******************************
  // interrupt pin
  // ******************************
  // open drain: pulled low while the light interrupt is pending
  assign intNOut = 1'b0;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      intNOe <= 1'b0;
    end else begin
      intNOe <= lightIntFlag_q;
    end
  end

  // ******************************
  // oscillator control
  // ******************************
  // the wired pin level is what stops the oscillator; no register bit moves
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      intLowMeta_q <= 1'b0;
      intLowSync_q <= 1'b0;
    end else begin
      intLowMeta_q <= ~intNIn;
      intLowSync_q <= intLowMeta_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oscEnable <= 1'b0;
    end else if (!powerOn) begin
      oscEnable <= 1'b0; // R10
    end else if (intCfg_q[SLEEP_INT_BIT] && intLowSync_q) begin
      oscEnable <= 1'b0; // R9 R10 R11
    end else begin
      oscEnable <= 1'b1; // R10 R12
    end
  end

endmodule

// *** tb/crrsc_host_model.sv ***
// serial host model that frames register writes and reads on the link
`timescale 1ns/100ps
module crrsc_host_model (
  output logic       scl,
  output logic       sdaLow,
  input  wire logic  sdaWire,
  output logic       rdValid,
  output logic [7:0] rdByte
);
  import crrsc_pkg::*;
  bit slow;
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
    rdValid = 1'b0;
    rdByte = 8'h00;
    slow = 1'b0;
  end
  // ****************
  // bit level
  // ****************
  // one link clock period, data already set; slow stretches the low phase
  task automatic pulse(output logic s);
    #(slow ? 200 : 40);
    scl = 1'b1;
    #1 s = sdaWire;
    #79 scl = 1'b0;
    #40;
  endtask
  task automatic start();
    sdaLow = 1'b0;
    #40 scl = 1'b1;
    #80 sdaLow = 1'b1;
    #80 scl = 1'b0;
    #40;
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    #40 scl = 1'b1;
    #80 sdaLow = 1'b0;
    #80;
  endtask
  task automatic sendByte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sdaLow = ~b[i];
      pulse(s);
    end
    sdaLow = 1'b0;
    pulse(s);
  endtask
  // ****************
  // register frames
  // ****************
  task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
    #3.3;
    start();
    sendByte({DEV_ADDR, 1'b0});
    sendByte(a);
    sendByte(d);
    stop();
  endtask
  // single byte read, ended by a not-acknowledge
  task automatic readReg(input logic [7:0] a);
    logic [7:0] d;
    logic       s;
    #3.3;
    start();
    sendByte({DEV_ADDR, 1'b0});
    sendByte(a);
    start();
    sendByte({DEV_ADDR, 1'b1});
    sdaLow = 1'b0;
    for (int i = 7; i >= 0; i--) pulse(d[i]);
    pulse(s);
    stop();
    rdByte = d;
    rdValid = 1'b1;
    #1 rdValid = 1'b0;
  endtask
endmodule

// *** tb/crrsc_regs_assertions.sv ***
// assertions on the colour result register bank ports
`timescale 1ns/100ps
module crrsc_regs_checker (
  input wire logic                   clk,
  input wire logic                   reset,
  input wire logic                   scl,
  input wire logic                   intNIn,
  input wire logic                   intNOe,
  input wire logic                   powerOn,
  input wire logic                   convDone,
  input wire logic                   lightIntEvent,
  input wire crrsc_pkg::crrsc_gain_e analogGain,
  input wire logic                   fourthChannelSelect,
  input wire logic                   oscEnable
);
  import crrsc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ****************
  // checks
  // ****************
  // a host access had its link clock high a few cycles earlier
  sequence linkActive;
    $past(scl, 4) || $past(scl, 6) || $past(scl, 8);
  endsequence
  chk_osc_no_power: assert property (!powerOn |=> !oscEnable)
    else $error("oscillator runs without power");
  chk_osc_int_idle: assert property ((powerOn && intNIn) [*4] |=> oscEnable)
    else $error("oscillator stopped with interrupt idle");
  chk_osc_int_gate: assert property ($fell(oscEnable) && $past(powerOn) |->
    !$past(intNIn, 2) || !$past(intNIn, 3) || !$past(intNIn, 4))
    else $error("oscillator stopped without interrupt");
  chk_int_raise: assert property (convDone && lightIntEvent |-> ##2 intNOe)
    else $error("interrupt not raised");
  chk_int_cause: assert property ($rose(intNOe) |-> $past(convDone, 2)
    && $past(lightIntEvent, 2))
    else $error("interrupt raised without event");
  chk_int_release: assert property ($fell(intNOe) |-> linkActive)
    else $error("interrupt cleared without host");
  chk_sel_by_link: assert property ($changed(fourthChannelSelect) |-> linkActive)
    else $error("channel select moved without host");
  chk_gain_by_link: assert property ($changed(analogGain) |-> linkActive)
    else $error("gain moved without host");
  chk_gain_range: assert property (analogGain <= GAIN_128X)
    else $error("gain code out of range");
  cov_int_sleep: cover property ($fell(oscEnable) && powerOn);
  cov_high_gain: cover property (analogGain == GAIN_128X);
  cov_int_clear: cover property ($fell(intNOe));
endmodule
bind crrsc_regs crrsc_regs_checker crrsc_regs_checker_i (
  .clk(clk), .reset(reset), .scl(scl), .intNIn(intNIn), .intNOe(intNOe),
  .powerOn(powerOn), .convDone(convDone), .lightIntEvent(lightIntEvent),
  .analogGain(analogGain), .fourthChannelSelect(fourthChannelSelect), .oscEnable(oscEnable)
);

// *** tb/crrsc_regs_tb.sv ***
// self-checking bench for the colour result register bank
`timescale 1ns/100ps
module crrsc_regs_tb;
  import crrsc_pkg::*;
  logic        clk, reset, scl, sdaIn, sdaOut, sdaOe, hostLow;
  logic        intNIn, intNOut, intNOe, powerOn, convDone, rdValid;
  logic        lightIntEvent, saturationEvent, fourthChannelSelect, oscEnable;
  crrsc_conv_s conv, cv;
  crrsc_gain_e analogGain;
  logic [7:0]  rdByte, r8;
  logic [7:0]  expQ[$], addrQ[$];
  logic [95:0] rnd;
  integer      seed;
  int          errors, n_tests;
  // open-drain wires with pull-ups
  assign sdaIn = ~(hostLow | (sdaOe & ~sdaOut));
  assign intNIn = ~(intNOe & ~intNOut);
  crrsc_regs crrsc_regs_i (
    .clk(clk), .reset(reset), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .intNIn(intNIn), .intNOut(intNOut), .intNOe(intNOe), .powerOn(powerOn),
    .convDone(convDone), .conv(conv), .lightIntEvent(lightIntEvent),
    .saturationEvent(saturationEvent), .analogGain(analogGain),
    .fourthChannelSelect(fourthChannelSelect), .oscEnable(oscEnable)
  );
  crrsc_host_model crrsc_host_model_i (
    .scl(scl), .sdaLow(hostLow), .sdaWire(sdaIn), .rdValid(rdValid), .rdByte(rdByte)
  );
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ****************
  // tasks
  // ****************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic checkRead(input logic [7:0] a, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] register %h expected %h seen %h", a, e, g);
    end
  endtask
  task automatic checkPin(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  always @(posedge rdValid) checkRead(addrQ.pop_front(), expQ.pop_front(), rdByte);
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    addrQ.push_back(a);
    crrsc_host_model_i.readReg(a);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    crrsc_host_model_i.writeReg(a, d);
  endtask
  task automatic convert(input logic le, input logic se);
    rnd = {$random(seed), $random(seed), $random(seed)};
    cv = rnd[79:0];
    @(posedge clk);
    #1 conv = cv;
    convDone = 1'b1;
    lightIntEvent = le;
    saturationEvent = se;
    @(posedge clk);
    #1 convDone = 1'b0;
    lightIntEvent = 1'b0;
    saturationEvent = 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic waitOsc(input logic v);
    repeat (30) begin
      if (oscEnable === v) break;
      @(posedge clk);
      #1;
    end
    checkPin("oscEnable", {7'h00, v}, {7'h00, oscEnable});
  endtask
  function automatic logic [7:0] expByte(input int i, input logic sel);
    logic [15:0] w;
    w = i < 2 ? cv.z : i < 4 ? cv.y : i < 6 ? cv.infraredA : sel ? cv.infraredB : cv.x;
    return i % 2 == 1 ? w[15:8] : w[7:0];
  endfunction
  // ****************
  // sequence
  // ****************
  initial begin
    #600000;
    errors++;
    complete_run();
  end
  initial begin
    seed = 32'hD2B0;
    reset = 1'b1;
    powerOn = 1'b0;
    convDone = 1'b0;
    conv = '0;
    cv = '0;
    lightIntEvent = 1'b0;
    saturationEvent = 1'b0;
    errors = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk);
    checkPin("oscEnable", 8'h00, {7'h00, oscEnable});
    checkPin("analogGain", {5'h00, GAIN_1X}, {5'h00, analogGain});
    crrsc_host_model_i.slow = 1'b1;
    for (int i = 0; i < 8; i++) rd(ADDR_Z_LO + 8'(i), 8'h00);
    crrsc_host_model_i.slow = 1'b0;
    rd(ADDR_HIGH_GAIN, HIGH_GAIN_RST);
    rd(ADDR_INT_CFG, INT_CFG_RST);
    convert(1'b0, 1'b0);
    for (int i = 0; i < 8; i++) rd(ADDR_Z_LO + 8'(i), expByte(i, 1'b0));
    wr(ADDR_Z_HI, 8'hA5);
    rd(ADDR_Z_HI, expByte(1, 1'b0));
    wr(ADDR_GAIN_CFG, 8'h08);
    checkPin("fourthChannelSelect", 8'h01, {7'h00, fourthChannelSelect});
    convert(1'b0, 1'b0);
    rd(ADDR_FOURTH_LO, expByte(6, 1'b1));
    rd(ADDR_FOURTH_HI, expByte(7, 1'b1));
    for (int h = 0; h < 2; h++) begin
      wr(ADDR_HIGH_GAIN, {3'h0, h[0], 4'h4});
      for (int g = 0; g < 4; g++) begin
        wr(ADDR_GAIN_CFG, {6'h00, g[1:0]});
        checkPin("analogGain", (h == 1 && g == 3) ? {5'h00, GAIN_128X} : 8'(g),
          {5'h00, analogGain});
      end
    end
    checkPin("fourthChannelSelect", 8'h00, {7'h00, fourthChannelSelect});
    r8 = 8'($random(seed));
    wr(ADDR_INT_CFG, {4'h0, r8[3:0]});
    rd(ADDR_INT_CFG, {4'h0, r8[3:0]});
    convert(1'b1, 1'b0);
    checkPin("intNOe", 8'h01, {7'h00, intNOe});
    rd(ADDR_STATUS, 8'h10);
    wr(ADDR_STATUS, 8'h10);
    rd(ADDR_STATUS, 8'h00);
    convert(1'b0, 1'b1);
    rd(ADDR_STATUS, 8'h80);
    wr(ADDR_STATUS, 8'h80);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_INT_CFG, 8'h8C);
    convert(1'b1, 1'b1);
    rd(ADDR_STATUS, 8'h90);
    rd(ADDR_STATUS, 8'h00);
    @(posedge clk);
    #1 powerOn = 1'b1;
    waitOsc(1'b1);
    wr(ADDR_INT_CFG, 8'h1C);
    convert(1'b1, 1'b0);
    waitOsc(1'b0);
    rd(ADDR_INT_CFG, 8'h1C);
    rd(ADDR_GAIN_CFG, 8'h03);
    wr(ADDR_STATUS, 8'h10);
    waitOsc(1'b1);
    @(posedge clk);
    #1 powerOn = 1'b0;
    waitOsc(1'b0);
    complete_run();
  end
endmodule
